// File: rtl/sscd_defs.vh
// sscd_defs.vh: named constants for the spi command decoder
// assumes: included by bare name from rtl and tb files
`ifndef SSCD_DEFS_VH
`define SSCD_DEFS_VH

// ----------------------------------------
// command field positions
// ----------------------------------------
`define SSCD_B_ACCEL 15
`define SSCD_B_AXIS 14
`define SSCD_B_OCS 13
`define SSCD_B_SD 5
`define SSCD_B_ARM 4
`define SSCD_ADDR_HI 12
`define SSCD_ADDR_LO 8
`define SSCD_DATA_HI 7
`define SSCD_DATA_LO 0
`define SSCD_FRAME_BITS 5'h10
`define SSCD_CNT_W 5

// ----------------------------------------
// config register bits
// ----------------------------------------
`define SSCD_CFG_SD 4
`define SSCD_CFG_ARM_A 2
`define SSCD_CFG_ARM_B 1
`define SSCD_CFG_RESET 8'h00
`define SSCD_CFG_LOCK 7
`define SSCD_CTL_RESET 8'h00
`define SSCD_CS_IDLE 1'b1

// ----------------------------------------
// register addresses and maps
// ----------------------------------------
`define SSCD_ADDR_CFG 5'h00
`define SSCD_ADDR_CTL 5'h01
`define SSCD_ADDR_STAT 5'h02
`define SSCD_STAT_MISO_BIT 0
`define SSCD_WR_MASK 32'h0000_0003
`define SSCD_RD_MASK 32'h0000_0007

// ----------------------------------------
// response kinds
// ----------------------------------------
`define SSCD_RSP_NONE 4'h0
`define SSCD_RSP_ACC_OC 4'h1
`define SSCD_RSP_ACC_RAW 4'h2
`define SSCD_RSP_WRITE 4'h3
`define SSCD_RSP_READ 4'h4
`define SSCD_RSP_SPI_ERR 4'h5
`define SSCD_RSP_MISO_ERR 4'h6
`define SSCD_RSP_INV_REG 4'h7
`define SSCD_RSP_INV_ACC 4'h8
`define SSCD_RSP_INT_ERR 4'h9
`define SSCD_RSP_ST_ERR 4'hA

`endif

// File: rtl/sscd_sync.v
// sscd_sync.v: two flop synchroniser for one async level
// assumes: din comes from a pin outside the ref_clk domain
`timescale 1ns/1ps

module sscd_sync #(
  // idle level of the pin, so reset leaves no false edge behind
  parameter RESET_VAL = 1'b0
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // level
  input wire din,
  output reg dout
);

  reg meta_reg;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= RESET_VAL;
      dout <= RESET_VAL;
    end else begin
      meta_reg <= din;
      dout <= meta_reg;
    end
  end

endmodule

// File: rtl/sscd_core.v
// sscd_core.v: spi command decoder of the sensor, spi slave side
// assumes: sclk and cs pins are async, sampled on REF_CLK (sclk far slower)
// What this block does
// - command bit 15 set means acceleration request, clear means register access.
// - axis 0 offset-select 0 is cancelled data, 0/1 raw, axis 1 invalid.
// - compare signed bit with config bit 4, arm bit with config bits 2 or 1.
// - any config mismatch flags request mismatch and sends no acceleration data.
// - every command carries odd parity over all sixteen bits; device checks it.
// - acceleration data only without init, reset, internal, spi, miso, mismatch, self-test faults.
// - a failing acceleration request gets the chosen exception response instead.
// - register access reads when access select is 0, writes when 1.
// - write carries address in bits 12..8 and data in bits 7..0.
// - write answer needs no spi, miso, invalid error, lock clear except control.
// - writes commit only after the frame ends, never after a spi error.
// - read answer needs no spi, miso or invalid error, else exception response.
// - sclk high at cs edges or not sixteen rising edges is a spi error.
// - driven miso bits are read back; any mismatch sets the mismatch flag.
// - mismatch flag holds until a successful read of the status register.
`timescale 1ns/1ps
`include "sscd_defs.vh"

module sscd_core (
  // clock and reset
  input wire REF_CLK,
  input wire RESETN,
  // spi pins
  input wire SCLK,
  input wire CS_N,
  input wire MOSI,
  input wire MISO_BACK,
  output reg MISO,
  output reg MISO_OE,
  // device flags
  input wire INIT_IN_PROGRESS_FLAG,
  input wire RESET_OCCURRED_FLAG,
  input wire INTERNAL_ERROR_FLAG,
  input wire SELF_TEST_ERROR,
  input wire [7:0] STATUS_OTHER,
  input wire [9:0] ACCEL_OC_DATA,
  input wire [9:0] ACCEL_RAW_DATA,
  // response frame for next message
  input wire [15:0] RESP_FRAME,
  output reg [3:0] RESP_KIND,
  output reg [7:0] RESP_DATA,
  // register side effects
  output reg [7:0] DEVICE_CONFIG_REG,
  output reg [7:0] DEVICE_CONTROL_REG,
  output reg OUTPUT_MISMATCH_FLAG,
  output reg STATUS_READ_PULSE,
  output reg FRAME_DONE_PULSE
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  wire sclk_s;
  wire cs_n_s;
  wire mosi_s;
  wire back_s;
  sscd_sync u_sync_sclk (.clk(REF_CLK), .rst_n(RESETN), .din(SCLK), .dout(sclk_s));
  // cs resets to its idle level so no frame is seen right after reset
  sscd_sync #(.RESET_VAL(`SSCD_CS_IDLE)) u_sync_cs (.clk(REF_CLK), .rst_n(RESETN),
    .din(CS_N), .dout(cs_n_s));
  sscd_sync u_sync_mosi (.clk(REF_CLK), .rst_n(RESETN), .din(MOSI), .dout(mosi_s));
  sscd_sync u_sync_back (.clk(REF_CLK), .rst_n(RESETN), .din(MISO_BACK), .dout(back_s));

  reg sclk_d_reg;
  reg cs_n_d_reg;
  wire sclk_rise = sclk_s & ~sclk_d_reg;
  wire sclk_fall = ~sclk_s & sclk_d_reg;
  wire cs_start = ~cs_n_s & cs_n_d_reg;
  wire cs_end = cs_n_s & ~cs_n_d_reg;

  // ----------------------------------------
  // frame capture
  // ----------------------------------------
  reg [15:0] shift_reg;
  reg [15:0] tx_reg;
  reg [`SSCD_CNT_W-1:0] cnt_reg;
  reg timing_err_reg;
  reg miso_err_reg;
  reg [3:0] kind_reg;
  reg [7:0] data_reg;

  // ----------------------------------------
  // decode of the finished frame
  // ----------------------------------------
  wire is_accel = shift_reg[`SSCD_B_ACCEL];
  wire axis_or_access_select = shift_reg[`SSCD_B_AXIS];
  wire offset_cancel_select = shift_reg[`SSCD_B_OCS];
  wire signed_data_select = shift_reg[`SSCD_B_SD];
  wire arm_select = shift_reg[`SSCD_B_ARM];
  wire [4:0] addr = shift_reg[`SSCD_ADDR_HI:`SSCD_ADDR_LO];
  wire [7:0] wdata = shift_reg[`SSCD_DATA_HI:`SSCD_DATA_LO];
  wire parity_ok = ^shift_reg;
  wire spi_err = timing_err_reg | (cnt_reg != `SSCD_FRAME_BITS) | ~parity_ok
    | (~is_accel & ~axis_or_access_select & (wdata != 8'h00));
  wire cfg_mismatch = (signed_data_select != DEVICE_CONFIG_REG[`SSCD_CFG_SD])
    | (arm_select != (DEVICE_CONFIG_REG[`SSCD_CFG_ARM_A]
    | DEVICE_CONFIG_REG[`SSCD_CFG_ARM_B]));
  wire config_lock_flag = DEVICE_CONFIG_REG[`SSCD_CFG_LOCK];
  // masks held as vectors so one bit is picked by address
  wire [31:0] wr_mask = `SSCD_WR_MASK;
  wire [31:0] rd_mask = `SSCD_RD_MASK;
  wire wr_ok_addr = wr_mask[addr];
  wire rd_ok_addr = rd_mask[addr];
  wire is_write = ~is_accel & axis_or_access_select;
  wire is_read = ~is_accel & ~axis_or_access_select;
  wire inv_reg = is_write ? (~wr_ok_addr | (config_lock_flag & (addr != `SSCD_ADDR_CTL)))
    : ~rd_ok_addr;
  wire [7:0] status_val = {STATUS_OTHER[7:1], OUTPUT_MISMATCH_FLAG};

  reg [3:0] kind_next;
  reg [7:0] data_next;
  always @* begin
    kind_next = `SSCD_RSP_NONE;
    data_next = 8'h00;
    if (spi_err) begin
      kind_next = `SSCD_RSP_SPI_ERR;
    end else if (miso_err_reg) begin
      kind_next = `SSCD_RSP_MISO_ERR;
    end else if (is_accel) begin
      if (axis_or_access_select | cfg_mismatch) begin
        kind_next = `SSCD_RSP_INV_ACC;
      end else if (INIT_IN_PROGRESS_FLAG | RESET_OCCURRED_FLAG) begin
        kind_next = `SSCD_RSP_INT_ERR;
      end else if (SELF_TEST_ERROR) begin
        kind_next = `SSCD_RSP_ST_ERR;
      end else if (INTERNAL_ERROR_FLAG) begin
        kind_next = `SSCD_RSP_INT_ERR;
      end else if (offset_cancel_select) begin
        kind_next = `SSCD_RSP_ACC_RAW;
        data_next = ACCEL_RAW_DATA[7:0];
      end else begin
        kind_next = `SSCD_RSP_ACC_OC;
        data_next = ACCEL_OC_DATA[7:0];
      end
    end else if (inv_reg) begin
      kind_next = `SSCD_RSP_INV_REG;
    end else if (is_write) begin
      kind_next = `SSCD_RSP_WRITE;
      data_next = wdata;
    end else begin
      kind_next = `SSCD_RSP_READ;
      case (addr)
        `SSCD_ADDR_CFG: data_next = DEVICE_CONFIG_REG;
        `SSCD_ADDR_CTL: data_next = DEVICE_CONTROL_REG;
        default: data_next = status_val;
      endcase
    end
  end

  wire commit_wr = is_write & ~spi_err & ~inv_reg;
  wire stat_read_ok = is_read & ~spi_err & ~miso_err_reg & ~inv_reg
    & (addr == `SSCD_ADDR_STAT);

  // ----------------------------------------
  // main sequential logic
  // ----------------------------------------
  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      sclk_d_reg <= 1'b0;
      cs_n_d_reg <= 1'b1;
      shift_reg <= 16'h0000;
      tx_reg <= 16'h0000;
      cnt_reg <= {`SSCD_CNT_W{1'b0}};
      timing_err_reg <= 1'b0;
      miso_err_reg <= 1'b0;
      kind_reg <= `SSCD_RSP_NONE;
      data_reg <= 8'h00;
      MISO <= 1'b0;
      MISO_OE <= 1'b0;
      RESP_KIND <= `SSCD_RSP_NONE;
      RESP_DATA <= 8'h00;
      DEVICE_CONFIG_REG <= `SSCD_CFG_RESET;
      DEVICE_CONTROL_REG <= `SSCD_CTL_RESET;
      OUTPUT_MISMATCH_FLAG <= 1'b0;
      STATUS_READ_PULSE <= 1'b0;
      FRAME_DONE_PULSE <= 1'b0;
    end else begin
      sclk_d_reg <= sclk_s;
      cs_n_d_reg <= cs_n_s;
      STATUS_READ_PULSE <= 1'b0;
      FRAME_DONE_PULSE <= 1'b0;
      if (cs_start) begin
        cnt_reg <= {`SSCD_CNT_W{1'b0}};
        timing_err_reg <= sclk_s;
        miso_err_reg <= 1'b0;
        tx_reg <= RESP_FRAME;
        MISO <= RESP_FRAME[15];
        MISO_OE <= 1'b1;
      end else if (~cs_n_s) begin
        if (sclk_rise) begin
          shift_reg <= {shift_reg[14:0], mosi_s};
          if (cnt_reg != {`SSCD_CNT_W{1'b1}}) begin
            cnt_reg <= cnt_reg + 1'b1;
          end
          if (back_s != MISO) begin
            miso_err_reg <= 1'b1;
          end
        end
        if (sclk_fall) begin
          tx_reg <= {tx_reg[14:0], 1'b0};
          MISO <= tx_reg[14];
        end
      end
      if (cs_end) begin
        MISO_OE <= 1'b0;
        FRAME_DONE_PULSE <= 1'b1;
        // late error on cs release folds into this frame
        timing_err_reg <= timing_err_reg | sclk_s;
      end
      // decode one cycle after release so the cs-end check is included
      if (FRAME_DONE_PULSE) begin
        RESP_KIND <= kind_next;
        RESP_DATA <= data_next;
        if (commit_wr) begin
          if (addr == `SSCD_ADDR_CFG) begin
            DEVICE_CONFIG_REG <= wdata;
          end else begin
            DEVICE_CONTROL_REG <= wdata;
          end
        end
        if (stat_read_ok) begin
          STATUS_READ_PULSE <= 1'b1;
        end
      end
      // set wins over clear
      if (miso_err_reg & FRAME_DONE_PULSE) begin
        OUTPUT_MISMATCH_FLAG <= 1'b1;
      end else if (FRAME_DONE_PULSE & stat_read_ok) begin
        OUTPUT_MISMATCH_FLAG <= 1'b0;
      end
    end
  end

endmodule

// File: tb/sscd_monitor.sv
// sscd_monitor.sv: port checker for sscd_core
// assumes: bound to each sscd_core, frames spaced per contract
`timescale 1ns/1ps
`include "sscd_defs.vh"
module sscd_monitor (
  // clock and reset
  input wire REF_CLK,
  input wire RESETN,
  // watched ports
  input wire CS_N,
  input wire MISO_OE,
  input wire [3:0] RESP_KIND,
  input wire [7:0] DEVICE_CONFIG_REG,
  input wire [7:0] DEVICE_CONTROL_REG,
  input wire OUTPUT_MISMATCH_FLAG,
  input wire STATUS_READ_PULSE,
  input wire FRAME_DONE_PULSE
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);
  // five cycles covers the pin synchroniser
  sequence cs_idle; CS_N [*5]; endsequence
  sequence cs_busy; !CS_N [*5]; endsequence
  chk_oe_idle: assert property (cs_idle |-> !MISO_OE)
    else $error("miso driven while deselected");
  chk_oe_busy: assert property (cs_busy |-> MISO_OE)
    else $error("miso released while selected");
  chk_done_one: assert property (FRAME_DONE_PULSE |=> !FRAME_DONE_PULSE)
    else $error("frame done longer than one cycle");
  chk_done_cs: assert property (FRAME_DONE_PULSE |-> CS_N && $past(CS_N))
    else $error("frame done before select released");
  chk_cfg_hold: assert property (!FRAME_DONE_PULSE |=> $stable(DEVICE_CONFIG_REG))
    else $error("config changed outside frame end");
  chk_ctl_hold: assert property (!FRAME_DONE_PULSE |=> $stable(DEVICE_CONTROL_REG))
    else $error("control changed outside frame end");
  chk_kind_hold: assert property (!FRAME_DONE_PULSE |=> $stable(RESP_KIND))
    else $error("response kind changed between frames");
  chk_stat_clear: assert property (STATUS_READ_PULSE |->
    RESP_KIND == `SSCD_RSP_READ ##1 !OUTPUT_MISMATCH_FLAG)
    else $error("status read did not clear flag");
  chk_flag_hold: assert property ($fell(OUTPUT_MISMATCH_FLAG) |->
    STATUS_READ_PULSE || $past(STATUS_READ_PULSE))
    else $error("mismatch flag cleared without status read");
endmodule
bind sscd_core sscd_monitor sscd_monitor_inst (.REF_CLK(REF_CLK), .RESETN(RESETN),
  .CS_N(CS_N), .MISO_OE(MISO_OE), .RESP_KIND(RESP_KIND),
  .DEVICE_CONFIG_REG(DEVICE_CONFIG_REG), .DEVICE_CONTROL_REG(DEVICE_CONTROL_REG),
  .OUTPUT_MISMATCH_FLAG(OUTPUT_MISMATCH_FLAG), .STATUS_READ_PULSE(STATUS_READ_PULSE),
  .FRAME_DONE_PULSE(FRAME_DONE_PULSE));

// File: tb/sscd_spi_master.sv
// sscd_spi_master.sv: behavioural spi master, 80 ns sclk
// assumes: caller spaces frames; sclk stands low between frames
`timescale 1ns/1ps
module sscd_spi_master (
  // serial pins
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  initial begin
    sclk = 0;
    cs_n = 1;
    mosi = 0;
  end
  // hi and n other than 16 break framing on purpose
  task automatic xfer(input logic [15:0] c, input int n, input bit hi,
                      output logic [15:0] rx);
    rx = 0;
    sclk = hi;
    mosi = c[15];
    #40 cs_n = 0;
    #40 sclk = 0;
    for (int i = 0; i < n; i++) begin
      mosi = c[15 - (i % 16)];
      #40 sclk = 1;
      rx = {rx[14:0], miso};
      #40 sclk = 0;
    end
    #40 cs_n = 1;
    mosi = ~mosi;
    #100;
  endtask
endmodule

// File: tb/tb_top.sv
// tb_top.sv: corner and random frames through sscd_core
// assumes: surroundings build RESP_FRAME as 5, kind, data
`timescale 1ns/1ps
module tb_top;
  logic clk = 0, rstn = 0, inj = 0, mf = 0, pdk = 1, dk, sp;
  logic sclk, cs_n, mosi, miso, mfo;
  logic [3:0] fl = 0, kind, pk = 0, k;
  logic [7:0] so = 0, cfg = 0, ctl = 0, pd = 0, rd, cd, td, d;
  logic [9:0] oc = 0, raw = 0;
  int seed = 25556, num_errors = 0, compares = 0;
  initial forever #2.5 clk = ~clk;
  sscd_spi_master sscd_spi_master_inst (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
  sscd_core sscd_core_inst (.REF_CLK(clk), .RESETN(rstn), .SCLK(sclk), .CS_N(cs_n),
    .MOSI(mosi), .MISO_BACK(miso ^ inj), .MISO(miso), .MISO_OE(),
    .INIT_IN_PROGRESS_FLAG(fl[3]), .RESET_OCCURRED_FLAG(fl[2]), .INTERNAL_ERROR_FLAG(fl[1]),
    .SELF_TEST_ERROR(fl[0]), .STATUS_OTHER(so), .ACCEL_OC_DATA(oc), .ACCEL_RAW_DATA(raw),
    .RESP_FRAME({4'h5, kind, rd}), .RESP_KIND(kind), .RESP_DATA(rd), .DEVICE_CONFIG_REG(cd),
    .DEVICE_CONTROL_REG(td), .OUTPUT_MISMATCH_FLAG(mfo), .STATUS_READ_PULSE(),
    .FRAME_DONE_PULSE());
  task automatic chk(input logic [15:0] g, e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // odd parity over all sixteen bits
  function automatic logic [15:0] par(input logic [15:0] c);
    int b;
    b = c[15] ? 12 : 13;
    c[b] = 0;
    c[b] = ~^c;
    return c;
  endfunction
  task automatic frame(input logic [15:0] c, input int n = 16, input bit hi = 0,
                       input bit bad = 0, input logic [3:0] f = 0);
    logic [15:0] rx;
    logic [4:0] a;
    a = c[12:8];
    @(posedge clk);
    #1;
    fl = f;
    so = $random(seed);
    oc = $random(seed);
    raw = $random(seed);
    fork
      sscd_spi_master_inst.xfer(c, n, hi, rx);
      begin
        #300 inj = bad;
        #80 inj = 0;
      end
    join
    d = 0;
    dk = 0;
    sp = n != 16 || hi || !(^c) || (!c[15] && !c[14] && c[7:0] != 0);
    if (sp) k = 5;
    else if (bad) k = 6;
    else if (c[15]) begin
      if (c[14] || c[5] != cfg[4] || c[4] != (cfg[2] | cfg[1])) k = 8;
      else if (f[3] | f[2]) k = 9;
      else if (f[0]) k = 4'hA;
      else if (f[1]) k = 9;
      else begin
        k = c[13] ? 4'h2 : 4'h1;
        d = c[13] ? raw[7:0] : oc[7:0];
        dk = 1;
      end
    end else if (c[14]) k = (a > 1 || (cfg[7] && a != 1)) ? 4'h7 : 4'h3;
    else if (a > 2) k = 7;
    else begin
      k = 4;
      d = a == 0 ? cfg : a == 1 ? ctl : {so[7:1], mf};
      dk = 1;
    end
    if (!sp && !c[15] && c[14] && a <= 1 && !(cfg[7] && a != 1)) begin
      if (a == 0) cfg = c[7:0];
      else ctl = c[7:0];
    end
    if (bad) mf = 1;
    else if (k == 4 && a == 2) mf = 0;
    chk(kind, k);
    if (dk) chk(rd, d);
    if (n == 16 && !hi) chk(rx[15:8], {4'h5, pk});
    if (n == 16 && !hi && pdk) chk(rx[7:0], pd);
    chk({cd, td}, {cfg, ctl});
    chk(mfo, mf);
    pk = k;
    pd = d;
    pdk = dk;
  endtask
  task automatic test_done;
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // 224 frames of roughly 1.5 us each, with margin
  initial begin
    #450_000;
    num_errors++;
    test_done;
  end
  // ----
  // main sequence
  // ----
  initial begin
    logic [31:0] r;
    logic [15:0] c;
    repeat (5) @(posedge clk);
    #1 rstn = 1;
    repeat (4) @(posedge clk);
    frame(par(16'h4016));
    frame(par(16'h8030));
    frame(par(16'hA030));
    frame(par(16'hC030));
    frame(par(16'h8010));
    frame(par(16'h41A5));
    frame(par(16'h0000));
    frame(par(16'h0100));
    frame(par(16'h0300));
    frame(par(16'h4255));
    frame(par(16'h0201));
    frame(par(16'h4011) ^ 16'h0001);
    frame(par(16'h8030), 15);
    frame(par(16'h8030), 17);
    frame(par(16'h8030), 16, 1);
    frame(par(16'h0200), 16, 0, 1);
    frame(par(16'h0200));
    for (int i = 0; i < 4; i++) frame(par(16'h8030), 16, 0, 0, 4'h1 << i);
    repeat (200) begin
      r = $random(seed);
      case (r[1:0])
        2'd0: c = {1'b1, r[2], r[3], 7'h00, r[4], r[5], 4'h0};
        2'd1: c = {6'h10, r[3:2], 1'b0, r[14:8]};
        default: c = {6'h00, r[3:2], 8'h00};
      endcase
      frame(par(c), 16, 0, r[7:5] == 0, r[10:8] == 0 ? r[19:16] : 4'h0);
    end
    frame(par(16'h4096), 16, 0, 1);
    frame(par(16'h4016));
    frame(par(16'h4133));
    test_done;
  end
endmodule
